// File: hdl/swsu_core.sv
// Module: single-wire service-mode UART command interpreter
`timescale 1ns/1ps
// Summary of operation
// - Each character: one start bit, eight data bits, one stop bit.
// - Bit rate is 2.4 kilobaud on both sides.
// - Entry byte 0x78 enters service mode; device only answers, never initiates.
// - Message is two command bytes, then optional 16-bit words as byte pairs.
// - Byte 1: bit0 fixed 1, bits1-6 end address, bit7 opcode bit 0.
// - Byte 2: bits0-1 opcode bits 1-2, bits2-7 start address.
// - Opcodes decode to refresh, compare, writes, reads, program, exit.
// - Refresh reloads start..end from non-volatile store; no data words.
// - Compare checks working memory against non-volatile store; no data words.
// - Program copies working memory into non-volatile store; no data words.
// - Runtime read and write use runtime space instead of configuration space.
// - One word per address, start to end inclusive, ascending.
// - Word counter advances only on correctly received words.
// - Commands other than exit with end below start are not executed.
// - Device waits one bit time before answering reads.
// - Device releases its driver after the answer.
// - Thirty idle bit times after a byte discard partial word, await command.
// - Exit with start 0 leaves service mode; otherwise enables output driver.
// - Master holds release level for the release time to disable driver.
// - While programming, new commands ignored and reception blocked until timeout.
module swsu_core
  import swsu_pkg::*;
#(
  parameter int unsigned BIT_CYCLES     = BIT_CYC,
  parameter int unsigned TIMEOUT_CYCLES = TIMEOUT_CYC,
  parameter int unsigned RELEASE_CYCLES = RELEASE_CYC,
  parameter int unsigned BURN_CYCLES    = BURN_CYC
) (
  input  wire logic          sys_clk,
  input  wire logic          rst_n,
  input  wire logic          wire_in,
  output logic               wire_out,
  output logic               wire_oe,
  input  wire logic          entry_window,
  output logic               service_mode,
  output logic               driver_enable,
  output swsu_mem_req_s      mem_req,
  output logic               mem_req_valid,
  input  wire logic [15:0]   mem_rdata,
  output swsu_nvm_req_s      nvm_req,
  input  wire logic          nvm_busy,
  input  wire logic          nvm_compare_ok,
  output logic [15:0]        compare_word
);
  localparam int unsigned HALF_CYCLES = BIT_CYCLES / 2;

  typedef enum logic [6:0] {
    S_CMD1  = 7'h01,
    S_CMD2  = 7'h02,
    S_WLO   = 7'h04,
    S_WHI   = 7'h08,
    S_GAP   = 7'h10,
    S_SEND  = 7'h20,
    S_BLOCK = 7'h40
  } swsu_ps_e;

  typedef enum logic [3:0] {
    R_IDLE  = 4'h1,
    R_START = 4'h2,
    R_DATA  = 4'h4,
    R_STOP  = 4'h8
  } swsu_rx_e;

  typedef struct packed {
    swsu_rx_e      rx;
    logic [31:0]   rcnt;
    logic [2:0]    rbit;
    logic [7:0]    rsh;
    logic          rdone;
    logic [7:0]    rbyte;
    logic          tx_busy;
    logic [31:0]   tcnt;
    logic [3:0]    tbit;
    logic [9:0]    tsh;
    swsu_ps_e      ps;
    logic          svc;
    logic          drv;
    logic [31:0]   tocnt;
    logic          armed;
    logic [31:0]   hcnt;
    logic [7:0]    b1;
    logic [7:0]    lo;
    logic [5:0]    ea;
    logic [5:0]    sa;
    logic [5:0]    addr;
    swsu_op_e      op;
    logic          hi_byte;
    logic [15:0]   tword;
    swsu_mem_req_s mreq;
    logic          mvalid;
    swsu_nvm_req_s nreq;
    logic          fetch_pend;
  } swsu_st_s;

  swsu_st_s    st_q;
  swsu_st_s    st_d;
  logic        f_in_valid;
  logic        f_in_ready;
  logic        f_out_valid;
  logic        f_out_ready;
  logic [15:0] f_out_data;
  logic        f_flush;
  logic [15:0] rd_word;

  // Compare result appears at bit 15 of live address 12
  assign rd_word = (st_q.op == fetch_live_words_cmd && st_q.addr == COMPARE_ADDR)
                   ? {nvm_compare_ok, mem_rdata[14:0]} : mem_rdata;

  assign compare_word  = {nvm_compare_ok, 15'h0000};
  assign f_flush       = (st_q.ps == S_CMD1);
  assign f_in_valid    = st_q.fetch_pend;
  assign f_out_ready   = (st_q.ps == S_SEND) && !st_q.tx_busy && !st_q.hi_byte;
  assign wire_out      = st_q.tsh[0] | ~st_q.tx_busy;
  assign wire_oe       = st_q.tx_busy;
  assign service_mode  = st_q.svc;
  assign driver_enable = st_q.drv;
  assign mem_req       = st_q.mreq;
  assign mem_req_valid = st_q.mvalid;
  assign nvm_req       = st_q.nreq;

  swsu_fifo #(
    .WIDTH     (16),
    .DEPTH     (FIFO_DEPTH)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .flush     (f_flush),
    .in_valid  (f_in_valid),
    .in_ready  (f_in_ready),
    .in_data   (rd_word),
    .out_valid (f_out_valid),
    .out_ready (f_out_ready),
    .out_data  (f_out_data)
  );

  always_comb
  begin
    st_d = st_q;
    st_d.rdone = 1'b0;
    st_d.mvalid = 1'b0;
    st_d.nreq.req = 1'b0;
    // Receiver, sampled mid-bit, LSB first, idle high
    case (st_q.rx)
      R_IDLE:
        if (!wire_in && !st_q.tx_busy)
        begin
          st_d.rx = R_START;
          st_d.rcnt = '0;
        end
      R_START:
        if (st_q.rcnt == HALF_CYCLES - 1)
        begin
          st_d.rcnt = '0;
          st_d.rbit = '0;
          st_d.rx = wire_in ? R_IDLE : R_DATA;
        end
        else
          st_d.rcnt = st_q.rcnt + 1;
      R_DATA:
        if (st_q.rcnt == BIT_CYCLES - 1)
        begin
          st_d.rcnt = '0;
          st_d.rsh = {wire_in, st_q.rsh[7:1]};
          st_d.rbit = st_q.rbit + 3'h1;
          if (st_q.rbit == 3'h7)
            st_d.rx = R_STOP;
        end
        else
          st_d.rcnt = st_q.rcnt + 1;
      R_STOP:
        if (st_q.rcnt == BIT_CYCLES - 1)
        begin
          st_d.rx = R_IDLE;
          st_d.rcnt = '0;
          // Framing errors drop the byte, so the word count never advances on it
          if (wire_in)
          begin
            st_d.rdone = 1'b1;
            st_d.rbyte = st_q.rsh;
          end
        end
        else
          st_d.rcnt = st_q.rcnt + 1;
      default:
        st_d.rx = R_IDLE;
    endcase

    // Transmitter
    if (st_q.tx_busy)
    begin
      if (st_q.tcnt == BIT_CYCLES - 1)
      begin
        st_d.tcnt = '0;
        st_d.tsh = {1'b1, st_q.tsh[9:1]};
        if (st_q.tbit == 4'd9)
          st_d.tx_busy = 1'b0;
        else
          st_d.tbit = st_q.tbit + 4'h1;
      end
      else
        st_d.tcnt = st_q.tcnt + 1;
    end

    // Inter-byte timeout
    if (st_q.rdone)
    begin
      st_d.tocnt = '0;
      st_d.armed = 1'b1;
    end
    else if (st_q.armed && st_q.rx == R_IDLE)
      st_d.tocnt = st_q.tocnt + 1;

    // Driver release: wire held high for the release time turns driver off
    if (st_q.drv)
    begin
      if (wire_in)
        st_d.hcnt = st_q.hcnt + 1;
      else
        st_d.hcnt = '0;
      if (st_q.hcnt == RELEASE_CYCLES - 1)
      begin
        st_d.drv = 1'b0;
        st_d.hcnt = '0;
      end
    end

    if (st_q.fetch_pend && f_in_ready)
    begin
      st_d.fetch_pend = 1'b0;
      st_d.addr = st_q.addr + 6'h01;
      if (st_q.addr != st_q.ea)
      begin
        st_d.mreq = '{we: 1'b0, live: st_q.op[0], addr: st_q.addr + 6'h01, wdata: '0};
        st_d.mvalid = 1'b1;
        st_d.fetch_pend = 1'b1;
      end
    end

    if (st_q.armed && st_q.tocnt == TIMEOUT_CYCLES - 1 && st_q.ps != S_SEND)
    begin
      st_d.armed = 1'b0;
      st_d.ps = S_CMD1;
    end
    else if (!st_q.svc)
    begin
      st_d.ps = S_CMD1;
      if (st_q.rdone && entry_window && st_q.rbyte == ENTRY_CODE)
        st_d.svc = 1'b1;
    end
    else
    begin
      case (st_q.ps)
        S_CMD1:
          if (st_q.rdone)
          begin
            if (nvm_busy)
              st_d.ps = S_BLOCK;
            else if (st_q.rbyte[0])
            begin
              st_d.b1 = st_q.rbyte;
              st_d.ps = S_CMD2;
            end
          end
        S_CMD2:
          if (st_q.rdone)
          begin
            st_d.ea = st_q.b1[6:1];
            st_d.op = swsu_op_e'({st_q.rbyte[1:0], st_q.b1[7]});
            st_d.sa = st_q.rbyte[7:2];
            st_d.addr = st_q.rbyte[7:2];
            st_d.ps = S_CMD1;
            case (swsu_op_e'({st_q.rbyte[1:0], st_q.b1[7]}))
              reload_from_nvm_cmd, compare_cmd, burn_nvm_cmd:
                if (st_q.b1[6:1] >= st_q.rbyte[7:2])
                begin
                  st_d.nreq = '{req: 1'b1, op: swsu_op_e'({st_q.rbyte[1:0], st_q.b1[7]}),
                                start_addr: st_q.rbyte[7:2],
                                end_addr: st_q.b1[6:1]};
                end
              store_cfg_words_cmd, store_live_words_cmd:
                if (st_q.b1[6:1] >= st_q.rbyte[7:2])
                begin
                  st_d.ps = S_WLO;
                  st_d.hi_byte = 1'b0;
                end
              fetch_cfg_words_cmd, fetch_live_words_cmd:
                if (st_q.b1[6:1] >= st_q.rbyte[7:2])
                begin
                  st_d.mreq = '{we: 1'b0, live: st_q.b1[7],
                                addr: st_q.rbyte[7:2], wdata: '0};
                  st_d.mvalid = 1'b1;
                  st_d.fetch_pend = 1'b1;
                  st_d.tocnt = '0;
                  st_d.ps = S_GAP;
                end
              exit_cmd:
                if (st_q.rbyte[7:2] == 6'h00)
                  st_d.svc = 1'b0;
                else
                begin
                  st_d.drv = 1'b1;
                  st_d.hcnt = '0;
                end
              default:
                st_d.ps = S_CMD1;
            endcase
          end
        S_WLO:
          if (st_q.rdone)
          begin
            st_d.lo = st_q.rbyte;
            st_d.ps = S_WHI;
          end
        S_WHI:
          if (st_q.rdone)
          begin
            st_d.mreq = '{we: 1'b1, live: st_q.op[0], addr: st_q.addr,
                          wdata: {st_q.rbyte, st_q.lo}};
            st_d.mvalid = 1'b1;
            st_d.addr = st_q.addr + 6'h01;
            st_d.ps = (st_q.addr == st_q.ea) ? S_CMD1 : S_WLO;
          end
        S_GAP:
          // One bit time of silence before answering
          if (st_q.tocnt == BIT_CYCLES - 1)
            st_d.ps = S_SEND;
        S_SEND:
          if (!st_q.tx_busy)
          begin
            // High byte of the current word goes out before the next word is taken
            if (st_q.hi_byte)
            begin
              st_d.tx_busy = 1'b1;
              st_d.tcnt = '0;
              st_d.tbit = '0;
              st_d.tsh = {1'b1, st_q.tword[15:8], 1'b0};
              st_d.hi_byte = 1'b0;
            end
            else if (f_out_valid)
            begin
              st_d.tx_busy = 1'b1;
              st_d.tcnt = '0;
              st_d.tbit = '0;
              st_d.tsh = {1'b1, f_out_data[7:0], 1'b0};
              st_d.tword = f_out_data;
              st_d.hi_byte = 1'b1;
            end
            else if (!st_q.fetch_pend)
            begin
              st_d.ps = S_CMD1;
              st_d.armed = 1'b0;
            end
          end
        S_BLOCK:
          st_d.ps = S_BLOCK;
        default:
          st_d.ps = S_CMD1;
      endcase
    end
    if (!st_q.svc)
      st_d.drv = 1'b0;
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q <= '0;
      st_q.rx <= R_IDLE;
      st_q.ps <= S_CMD1;
      st_q.tsh <= 10'h3FF;
    end
    else
      st_q <= st_d;
  end
endmodule : swsu_core

// File: hdl/swsu_pkg.sv
// Package: constants, enums and carriers for the single-wire service UART
package swsu_pkg;
  localparam int unsigned CLK_HZ          = 250_000_000;
  localparam int unsigned BAUD_HZ         = 2_400;
  localparam int unsigned BIT_CYC         = CLK_HZ / BAUD_HZ;
  localparam int unsigned HALF_CYC        = BIT_CYC / 2;
  localparam int unsigned TIMEOUT_BITS    = 30;
  localparam int unsigned TIMEOUT_CYC     = TIMEOUT_BITS * BIT_CYC;
  localparam int unsigned RELEASE_US      = 1000;
  localparam int unsigned RELEASE_CYC     = RELEASE_US * (CLK_HZ / 1_000_000);
  localparam int unsigned BURN_US         = 10000;
  localparam int unsigned BURN_CYC        = BURN_US * (CLK_HZ / 1_000_000);
  localparam logic [7:0]  ENTRY_CODE      = 8'h78;
  localparam logic [5:0]  COMPARE_ADDR    = 6'h0C;
  localparam int unsigned COMPARE_BIT     = 15;
  localparam int unsigned FIFO_DEPTH      = 8;

  typedef enum logic [2:0] {
    reload_from_nvm_cmd   = 3'h0,
    compare_cmd           = 3'h1,
    store_cfg_words_cmd   = 3'h2,
    store_live_words_cmd  = 3'h3,
    fetch_cfg_words_cmd   = 3'h4,
    fetch_live_words_cmd  = 3'h5,
    burn_nvm_cmd          = 3'h6,
    exit_cmd              = 3'h7
  } swsu_op_e;

  typedef struct packed {
    logic       we;
    logic       live;
    logic [5:0] addr;
    logic [15:0] wdata;
  } swsu_mem_req_s;

  typedef struct packed {
    logic       req;
    swsu_op_e   op;
    logic [5:0] start_addr;
    logic [5:0] end_addr;
  } swsu_nvm_req_s;
endpackage : swsu_pkg

// File: hdl/swsu_fifo.sv
// Module: small synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module swsu_fifo
  import swsu_pkg::*;
#(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DEPTH = FIFO_DEPTH
) (
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  input  wire logic             flush,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int unsigned AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   cnt;
  } swsu_fifo_st_s;
  swsu_fifo_st_s     st_q;
  swsu_fifo_st_s     st_d;
  logic [WIDTH-1:0]  mem [DEPTH];
  logic              push;
  logic              pop;

  assign in_ready  = (st_q.cnt != (AW+1)'(DEPTH));
  assign out_valid = (st_q.cnt != '0);
  assign out_data  = mem[st_q.rp];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_comb
  begin
    st_d = st_q;
    if (push)
      st_d.wp = (st_q.wp == AW'(DEPTH-1)) ? '0 : st_q.wp + 1'b1;
    if (pop)
      st_d.rp = (st_q.rp == AW'(DEPTH-1)) ? '0 : st_q.rp + 1'b1;
    if (push && !pop)
      st_d.cnt = st_q.cnt + 1'b1;
    else if (pop && !push)
      st_d.cnt = st_q.cnt - 1'b1;
    if (flush)
      st_d = '0;
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  always_ff @(posedge sys_clk)
  begin
    if (push)
      mem[st_q.wp] <= in_data;
  end
endmodule : swsu_fifo

// File: tb/swsu_core_chk.sv
// Port-level assertions for the service UART core
`timescale 1ns/1ps
module swsu_core_chk
  import swsu_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYCLES = TIMEOUT_CYC,
  parameter int unsigned RELEASE_CYCLES = RELEASE_CYC,
  parameter int unsigned BURN_CYCLES    = BURN_CYC
) (
  input wire logic          sys_clk,
  input wire logic          rst_n,
  input wire logic          wire_in,
  input wire logic          wire_out,
  input wire logic          wire_oe,
  input wire logic          service_mode,
  input wire logic          driver_enable,
  input wire logic          mem_req_valid,
  input wire swsu_mem_req_s mem_req,
  input wire swsu_nvm_req_s nvm_req,
  input wire logic          nvm_compare_ok,
  input wire logic [15:0]   compare_word
);
  logic [31:0] hi_cnt_q;
  // Cycles of high wire while the output driver is on
  always_ff @(posedge sys_clk or negedge rst_n)
    if (!rst_n)
      hi_cnt_q <= 32'h0;
    else if (driver_enable && wire_in)
      hi_cnt_q <= hi_cnt_q + 32'h1;
    else
      hi_cnt_q <= 32'h0;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  a_idle_high: assert property (!wire_oe |-> wire_out)
    else $error("wire_out low while released");
  a_start_driven: assert property ($fell(wire_out) |-> wire_oe)
    else $error("start bit without drive");
  a_stop_release: assert property ($fell(wire_oe) |-> $past(wire_out))
    else $error("released before a high stop bit");
  a_talk_service: assert property (wire_oe |-> service_mode)
    else $error("driving outside service mode");
  a_mem_pulse: assert property (mem_req_valid |-> service_mode ##1
    (!mem_req_valid || mem_req.addr == $past(mem_req.addr) + 6'h01))
    else $error("memory requests out of address order or outside service mode");
  a_nvm_range: assert property (nvm_req.req |-> nvm_req.end_addr >= nvm_req.start_addr)
    else $error("nvm request with end below start");
  a_nvm_ops: assert property (nvm_req.req |-> nvm_req.op inside {reload_from_nvm_cmd,
    compare_cmd, burn_nvm_cmd} ##1 !nvm_req.req)
    else $error("bad nvm request opcode or length");
  a_drv_service: assert property (driver_enable |-> service_mode)
    else $error("driver enabled outside service mode");
  a_drv_release: assert property (hi_cnt_q <= RELEASE_CYCLES + 2)
    else $error("driver not released after high pulse");
  a_cmp_word: assert property (compare_word == {nvm_compare_ok, 15'h0})
    else $error("compare word mismatch");
endmodule : swsu_core_chk

bind swsu_core swsu_core_chk #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES),
  .RELEASE_CYCLES(RELEASE_CYCLES), .BURN_CYCLES(BURN_CYCLES)) i_chk (
  .sys_clk(sys_clk), .rst_n(rst_n), .wire_in(wire_in), .wire_out(wire_out),
  .wire_oe(wire_oe), .service_mode(service_mode), .driver_enable(driver_enable),
  .mem_req_valid(mem_req_valid), .mem_req(mem_req), .nvm_req(nvm_req),
  .nvm_compare_ok(nvm_compare_ok),
  .compare_word(compare_word));

// File: tb/swsu_master.sv
// Calibration master model with a single-wire transceiver
`timescale 1ns/1ps
module swsu_master
  import swsu_pkg::*;
#(
  parameter int unsigned BIT_CYCLES = BIT_CYC
) (
  input  wire logic sys_clk,
  input  wire logic wire_lvl,
  output logic      m_oe,
  output logic      m_val,
  output logic [7:0] rx_byte,
  output logic      rx_stb
);
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] frame;
    frame = {1'b1, b, 1'b0};
    m_oe = 1'b1;
    for (int i = 0; i < 10; i++)
    begin
      m_val = frame[i];
      repeat (BIT_CYCLES) @(negedge sys_clk);
    end
    m_oe = 1'b0;
    // One released cycle keeps the next byte's enable in a later time step
    @(negedge sys_clk);
  endtask : send_byte
  task automatic hold_high(input int unsigned n);
    m_oe = 1'b1;
    m_val = 1'b1;
    repeat (n) @(negedge sys_clk);
    m_oe = 1'b0;
    @(negedge sys_clk);
  endtask : hold_high
  // Receiver, mid-bit sampling while released
  initial
  begin
    m_oe = 1'b0;
    m_val = 1'b1;
    rx_byte = 8'h00;
    rx_stb = 1'b0;
    forever
    begin
      @(negedge sys_clk);
      if (!m_oe && wire_lvl === 1'b0)
      begin
        repeat (BIT_CYCLES / 2) @(negedge sys_clk);
        for (int i = 0; i < 8; i++)
        begin
          repeat (BIT_CYCLES) @(negedge sys_clk);
          rx_byte[i] = wire_lvl;
        end
        repeat (BIT_CYCLES) @(negedge sys_clk);
        @(posedge sys_clk);
        rx_stb = wire_lvl;
        @(posedge sys_clk);
        rx_stb = 1'b0;
      end
    end
  end
endmodule : swsu_master

// File: tb/tb_swsu_core.sv
// Self-checking testbench for the service UART core
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_fail++; \
  $display("Error at %0t: got %h expected %h", $time, g, e); end end
module tb_swsu_core
  import swsu_pkg::*;
;
  localparam int unsigned REL = 100;
  localparam int unsigned TB_BIT = 32;
  logic          sys_clk, rst_n, wire_in, entry_window, nvm_busy, nvm_compare_ok;
  logic          wire_out, wire_oe, service_mode, driver_enable, mem_req_valid;
  logic          m_oe, m_val, rx_stb, drv_seen;
  logic [15:0]   mem_rdata, compare_word;
  logic [15:0]   wd[2], rd_base, rw;
  logic [7:0]    rx_byte;
  swsu_mem_req_s mem_req;
  swsu_nvm_req_s nvm_req;
  logic [27:0]   notes[$];
  int            n_fail, n_compared;
  swsu_op_e      ops[3] = '{reload_from_nvm_cmd, compare_cmd, burn_nvm_cmd};

  // Pulled-up wire, either side may pull it low
  assign wire_in = (wire_oe ? wire_out : 1'b1) & (m_oe ? m_val : 1'b1);
  // Memory model: read data follows the requested address
  assign mem_rdata = rd_base ^ {10'h000, mem_req.addr};

  swsu_core #(.BIT_CYCLES(TB_BIT), .TIMEOUT_CYCLES(TIMEOUT_BITS * TB_BIT),
    .RELEASE_CYCLES(REL), .BURN_CYCLES(1000)) i_dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .wire_in(wire_in), .wire_out(wire_out),
    .wire_oe(wire_oe), .entry_window(entry_window), .service_mode(service_mode),
    .driver_enable(driver_enable), .mem_req(mem_req), .mem_req_valid(mem_req_valid),
    .mem_rdata(mem_rdata), .nvm_req(nvm_req), .nvm_busy(nvm_busy),
    .nvm_compare_ok(nvm_compare_ok), .compare_word(compare_word));
  swsu_master #(.BIT_CYCLES(TB_BIT)) i_mst (.sys_clk(sys_clk), .wire_lvl(wire_in),
    .m_oe(m_oe), .m_val(m_val),
    .rx_byte(rx_byte), .rx_stb(rx_stb));

  initial
  begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  task automatic results;
    $display("compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : results

  task automatic cmd(input swsu_op_e op, input logic [5:0] s, input logic [5:0] e);
    logic [2:0] c;
    c = op;
    i_mst.send_byte({c[0], e, 1'b1});
    i_mst.send_byte({s, c[2:1]});
  endtask : cmd

  task automatic word(input logic [15:0] v);
    i_mst.send_byte(v[7:0]);
    i_mst.send_byte(v[15:8]);
  endtask : word

  task automatic take(input logic [27:0] got);
    logic [27:0] exp;
    if (notes.size() == 0)
    begin
      n_fail++;
      $display("Error at %0t: unexpected result %h", $time, got);
    end
    else
    begin
      exp = notes.pop_front();
      `CHK(got, exp)
    end
  endtask : take

  task automatic drain(input string name);
    for (int i = 0; i < 60 * TB_BIT && notes.size() != 0; i++)
      @(negedge sys_clk);
    repeat (2 * TB_BIT) @(negedge sys_clk);
    `CHK(notes.size(), 0)
    $display("test %s done", name);
  endtask : drain

  // Result watcher: compares each result with the oldest note
  always @(negedge sys_clk)
  begin
    if (rst_n && mem_req_valid)
      take({4'h1, mem_req.we, mem_req.live, mem_req.addr,
            mem_req.we ? mem_req.wdata : 16'h0});
    if (rst_n && nvm_req.req)
      take({12'h200, nvm_req});
    if (rx_stb)
      take({20'h30000, rx_byte});
    if (driver_enable)
      drv_seen = 1'b1;
  end

  initial
  begin
    repeat (1200 * TB_BIT) @(posedge sys_clk);
    n_fail++;
    $display("Error at %0t: watchdog expired", $time);
    results();
  end

  initial
  begin
    void'($urandom(47384));
    {entry_window, nvm_busy, nvm_compare_ok, drv_seen, rst_n} = 5'h0;
    rd_base = 16'h0000;
    repeat (10) @(negedge sys_clk);
    rst_n = 1'b1;
    `CHK(wire_out, 1'b1)
    `CHK(wire_oe, 1'b0)
    `CHK(service_mode, 1'b0)
    entry_window = 1'b1;
    i_mst.send_byte(ENTRY_CODE);
    entry_window = 1'b0;
    repeat (4) @(negedge sys_clk);
    `CHK(service_mode, 1'b1)
    $display("test entry done");
    // Lone low byte, then silence: must be dropped
    cmd(store_live_words_cmd, 6'd9, 6'd9);
    i_mst.send_byte(8'hA5);
    repeat ((TIMEOUT_BITS + 1) * TB_BIT) @(negedge sys_clk);
    wd[0] = 16'($urandom);
    wd[1] = 16'($urandom);
    notes.push_back({4'h1, 2'b10, 6'd3, wd[0]});
    notes.push_back({4'h1, 2'b10, 6'd4, wd[1]});
    cmd(store_cfg_words_cmd, 6'd3, 6'd4);
    word(wd[0]);
    word(wd[1]);
    drain("write");
    // Two-word reads: configuration 5..6, then live 11..12 with the compare flag
    nvm_compare_ok = 1'b1;
    for (int k = 0; k < 2; k++)
    begin
      rd_base = 16'($urandom);
      for (int a = 0; a < 2; a++)
        notes.push_back({4'h1, 1'b0, k[0], 6'(5 + 6 * k + a), 16'h0});
      for (int a = 0; a < 2; a++)
      begin
        rw = rd_base ^ 16'(5 + 6 * k + a);
        if (k == 1 && a == 1)
          rw[COMPARE_BIT] = nvm_compare_ok;
        notes.push_back({20'h30000, rw[7:0]});
        notes.push_back({20'h30000, rw[15:8]});
      end
      cmd(k[0] ? fetch_live_words_cmd : fetch_cfg_words_cmd, 6'(5 + 6 * k), 6'(6 + 6 * k));
      drain("read");
    end
    foreach (ops[k])
    begin
      notes.push_back({12'h200, 1'b1, ops[k], 6'd2, 6'd6});
      cmd(ops[k], 6'd2, 6'd6);
      drain("nvm");
    end
    nvm_busy = 1'b1;
    cmd(reload_from_nvm_cmd, 6'd0, 6'd1);
    repeat ((TIMEOUT_BITS + 1) * TB_BIT) @(negedge sys_clk);
    nvm_busy = 1'b0;
    cmd(reload_from_nvm_cmd, 6'd5, 6'd3);
    notes.push_back({12'h200, 1'b1, reload_from_nvm_cmd, 6'd5, 6'd5});
    cmd(reload_from_nvm_cmd, 6'd5, 6'd5);
    drain("busy");
    nvm_compare_ok = 1'b1;
    cmd(exit_cmd, 6'd1, 6'd1);
    `CHK(driver_enable, 1'b1)
    i_mst.hold_high(REL + 10);
    `CHK(drv_seen, 1'b1)
    `CHK(driver_enable, 1'b0)
    `CHK(service_mode, 1'b1)
    cmd(exit_cmd, 6'd0, 6'd0);
    repeat (4) @(negedge sys_clk);
    `CHK(service_mode, 1'b0)
    $display("test exit done");
    results();
  end
endmodule : tb_swsu_core
